// ===== design/strap_led_pkg.sv
package strap_led_pkg;
  localparam int          PIN_COUNT        = 5;
  // pin indices, equal to the management address bit they strap
  localparam int          PIN_ACTIVITY     = 0;
  localparam int          PIN_COLLISION    = 1;
  localparam int          PIN_LINK         = 2;
  localparam int          PIN_TX           = 3;
  localparam int          PIN_RX           = 4;
  // collision stretch time and its count at 10 MHz
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          COL_STRETCH_MS   = 70;
  localparam int          COL_STRETCH_CYC  = (COL_STRETCH_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [4:0]  ADDR_RESET       = 5'h00;
  localparam logic [1:0]  SYNC_RESET       = 2'h0;
endpackage : strap_led_pkg

// ===== design/strap_sample_led_pins.sv
// Function
// - pins are inputs in reset, captured at exit
// - after capture pins drive status outputs
// - software reset keeps straps and pin direction
// - asserted drive level is inverse of strap
// - low strap gives address bit zero
// - bit 0 pin shows receive or transmit
// - bit 1 pin shows collision status
// - collision indication stretched about 70 ms
// - bit 2 pin shows valid link
// - bit 3 pin shows transmit activity
// - bit 4 pin shows receive activity
`timescale 1ns/10ps
`default_nettype none
module strap_sample_led_pins
  import strap_led_pkg::*;
#(
  parameter int STRETCH_CYCLES = COL_STRETCH_CYC
) (
  // clock and hardware reset
  input  wire  logic                 MCLK_I,
  input  wire  logic                 RESET_N_I,
  // software reset, has no effect on the pins
  input  wire  logic                 SW_RESET_I,
  // status from the transceiver core
  input  wire  logic                 TX_ACTIVE_I,
  input  wire  logic                 RX_ACTIVE_I,
  input  wire  logic                 LINK_VALID_I,
  input  wire  logic                 COLLISION_I,
  // multiplexed pins
  input  wire  logic [PIN_COUNT-1:0] PIN_I,
  output var   logic [PIN_COUNT-1:0] PIN_O,
  output var   logic [PIN_COUNT-1:0] PIN_OE_N_O,
  // captured management address
  output var   logic [PIN_COUNT-1:0] MGMT_STATION_ADDRESS_O,
  output var   logic                 ADDR_VALID_O
);

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'h0,
    ST_DRIVE  = 2'h1
  } phase_e;

  localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);

  // sampling or driving
  phase_e                 phase_reg;
  phase_e                 phase_next;
  // pin synchroniser
  logic [PIN_COUNT-1:0]   sync1_reg;
  logic [PIN_COUNT-1:0]   sync1_next;
  logic [PIN_COUNT-1:0]   sync2_reg;
  logic [PIN_COUNT-1:0]   sync2_next;
  // captured address
  logic [PIN_COUNT-1:0]   addr_reg;
  logic [PIN_COUNT-1:0]   addr_next;
  // pin drivers
  logic [PIN_COUNT-1:0]   pin_reg;
  logic [PIN_COUNT-1:0]   pin_next;
  logic [PIN_COUNT-1:0]   oe_n_reg;
  logic [PIN_COUNT-1:0]   oe_n_next;
  // collision stretch
  logic [CNT_W-1:0]       col_cnt_reg;
  logic [CNT_W-1:0]       col_cnt_next;
  // address valid flag
  logic                   valid_reg;
  logic                   valid_next;
  // status and drive levels
  logic [PIN_COUNT-1:0]   status;
  logic [PIN_COUNT-1:0]   level;
  logic                   col_led;

  // pin synchroniser, not reset so it tracks the straps through reset
  always_comb begin
    sync1_next = PIN_I;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge MCLK_I) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  // collision stretch counter
  always_comb begin
    col_cnt_next = col_cnt_reg;
    if (COLLISION_I) begin
      col_cnt_next = CNT_W'(STRETCH_CYCLES);
    end else if (col_cnt_reg != '0) begin
      col_cnt_next = col_cnt_reg - 1'b1;
    end
  end
  assign col_led = COLLISION_I || (col_cnt_reg != '0);

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      col_cnt_reg <= '0;
    end else begin
      col_cnt_reg <= col_cnt_next;
    end
  end

  // status per pin
  always_comb begin
    status                = '0;
    status[PIN_ACTIVITY]  = RX_ACTIVE_I || TX_ACTIVE_I;
    status[PIN_COLLISION] = col_led;
    status[PIN_LINK]      = LINK_VALID_I;
    status[PIN_TX]        = TX_ACTIVE_I;
    status[PIN_RX]        = RX_ACTIVE_I;
  end

  // asserted level is the inverse of the strap
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_level
    assign level[g] = status[g] ^ addr_reg[g];
  end

  // phase; SW_RESET_I deliberately not used
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      ST_SAMPLE: begin
        phase_next = ST_DRIVE;
      end
      ST_DRIVE: begin
        phase_next = ST_DRIVE;
      end
      default: begin
        phase_next = ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phase_reg <= ST_SAMPLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // address capture at reset exit
  always_comb begin
    addr_next = addr_reg;
    unique case (phase_reg)
      ST_SAMPLE: begin
        addr_next = sync2_reg;
      end
      ST_DRIVE: begin
        addr_next = addr_reg;
      end
      default: begin
        addr_next = addr_reg;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      addr_reg <= ADDR_RESET;
    end else begin
      addr_reg <= addr_next;
    end
  end

  // pin drivers
  always_comb begin
    pin_next  = pin_reg;
    oe_n_next = oe_n_reg;
    unique case (phase_reg)
      ST_SAMPLE: begin
        oe_n_next = {PIN_COUNT{1'b1}};
      end
      ST_DRIVE: begin
        oe_n_next = {PIN_COUNT{1'b0}};
        pin_next  = level;
      end
      default: begin
        oe_n_next = {PIN_COUNT{1'b1}};
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_reg  <= {PIN_COUNT{1'b0}};
      oe_n_reg <= {PIN_COUNT{1'b1}};
    end else begin
      pin_reg  <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // address valid once the pins drive
  always_comb begin
    valid_next = 1'b0;
    unique case (phase_reg)
      ST_SAMPLE: begin
        valid_next = 1'b0;
      end
      ST_DRIVE: begin
        valid_next = 1'b1;
      end
      default: begin
        valid_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
    end
  end

  // outputs
  assign PIN_O                  = pin_reg;
  assign PIN_OE_N_O             = oe_n_reg;
  assign MGMT_STATION_ADDRESS_O = addr_reg;
  assign ADDR_VALID_O           = valid_reg;

endmodule : strap_sample_led_pins
`default_nettype wire

// ===== tb/board_pulls.sv
`timescale 1ns/10ps
`default_nettype none
module board_pulls (
  input  wire logic [4:0] strap_i,
  input  wire logic [4:0] drv_i,
  input  wire logic [4:0] oe_n_i,
  output logic      [4:0] pin_o
);
  assign pin_o = (oe_n_i & strap_i) | (~oe_n_i & drv_i);
endmodule : board_pulls
`default_nettype wire

// ===== tb/strap_pins_checker.sv
`timescale 1ns/10ps
`default_nettype none
module strap_pins_checker
  import strap_led_pkg::*;
(
  input wire logic MCLK_I, RESET_N_I, SW_RESET_I, TX_ACTIVE_I, RX_ACTIVE_I, LINK_VALID_I,
  input wire logic COLLISION_I, ADDR_VALID_O,
  input wire logic [PIN_COUNT-1:0] PIN_I, PIN_O, PIN_OE_N_O, MGMT_STATION_ADDRESS_O
);
  logic v2_reg;
  wire s = ADDR_VALID_O & v2_reg;
  wire [4:0] a = MGMT_STATION_ADDRESS_O;
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) v2_reg <= 1'b0;
    else v2_reg <= ADDR_VALID_O;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  drive_on_a: assert property (ADDR_VALID_O |-> PIN_OE_N_O == 5'h00) else $error("oe");
  addr_hold_a: assert property (s |-> $stable(a)) else $error("addr");
  act_led_a: assert property (s |-> PIN_O[0] ==
    (a[0] ^ ($past(TX_ACTIVE_I) | $past(RX_ACTIVE_I)))) else $error("act");
  col_led_a: assert property ($past(COLLISION_I) && s |-> PIN_O[1] == ~a[1]) else $error("col");
  link_led_a: assert property (s |-> PIN_O[2] == (a[2] ^ $past(LINK_VALID_I))) else $error("lk");
  tx_led_a: assert property (s |-> PIN_O[3] == (a[3] ^ $past(TX_ACTIVE_I))) else $error("tx");
  rx_led_a: assert property (s |-> PIN_O[4] == (a[4] ^ $past(RX_ACTIVE_I))) else $error("rx");
  swr_keep_a: assert property (ADDR_VALID_O && SW_RESET_I |=> ADDR_VALID_O) else $error("sw");
  drv_off_a: assert property (!ADDR_VALID_O |-> PIN_OE_N_O == 5'h1F) else $error("oe off");
endmodule : strap_pins_checker
bind strap_sample_led_pins strap_pins_checker u_chk (.*);
`default_nettype wire

// ===== tb/tb_strap_sample_led_pins.sv
`timescale 1ns/10ps
`default_nettype none
module tb_strap_sample_led_pins;
  logic clk = 0, rst_n = 0, swr = 0, tx = 0, rx = 0, lk = 0, col = 0, chk = 0, vld;
  logic [4:0] strap = 5'h00, pin, po, oen, addr;
  logic [31:0] lf = 32'hC90DBF60;
  logic [9:0] q[$], e;
  int fails = 0, tests_run = 0;
  always #50 clk = ~clk;
  board_pulls u_pull (.strap_i(strap), .drv_i(po), .oe_n_i(oen), .pin_o(pin));
  strap_sample_led_pins #(.STRETCH_CYCLES(8)) u_dut (.MCLK_I(clk), .RESET_N_I(rst_n),
    .SW_RESET_I(swr), .TX_ACTIVE_I(tx), .RX_ACTIVE_I(rx), .LINK_VALID_I(lk), .COLLISION_I(col),
    .PIN_I(pin), .PIN_O(po), .PIN_OE_N_O(oen), .MGMT_STATION_ADDRESS_O(addr), .ADDR_VALID_O(vld));
  task automatic tally_and_finish;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // st = {rx, tx, link, collision, sw reset}; ce = collision indication expected
  task automatic drv(input logic [4:0] st, input logic ce);
    @(negedge clk);
    {rx, tx, lk, col, swr} = st;
    q.push_back({strap, strap ^ {st[4], st[3], st[2], ce, st[4] | st[3]}});
    chk = 1;
  endtask : drv
  task automatic idle(input int n);
    @(negedge clk);
    {chk, rx, tx, lk, col, swr} = 6'h00;
    repeat (n - 1) @(negedge clk);
  endtask : idle
  always @(posedge clk) begin
    #10;
    if (chk) begin
      e = q.pop_front();
      tests_run++;
      if ({addr, po} !== e) begin
        fails++;
        $display("FAIL addr_and_leds expected %h seen %h", e, {addr, po});
      end
    end
  end
  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end
  initial begin
    for (int k = 0; k < 3; k++) begin
      idle(1);
      rst_n = 0;
      lf = lfsr_next(lf);
      strap = lf[4:0];
      repeat (20) @(negedge clk);
      rst_n = 1;
      for (int i = 0; i < 10 && vld !== 1'b1; i++) @(negedge clk);
      repeat (24) begin
        lf = lfsr_next(lf);
        drv({lf[6:4], 1'b0, lf[7]}, 1'b0);
      end
      drv(5'h02, 1'b1);
      repeat (4) drv(5'h00, 1'b1);
      idle(12);
      drv(5'h00, 1'b0);
    end
    tally_and_finish();
  end
endmodule : tb_strap_sample_led_pins
`default_nettype wire
